// [rtl/clk_pg_cfg_pkg.sv]
// Purpose: shared constants and types for the clock and supply monitor config block
// Assumes: byte-wide registers on a 32-bit APB data path, index times four gives the address
// Notes: otp defaults arrive as a struct on the top-level port
package clk_pg_cfg_pkg;

  // register indices as printed, byte address is four times the index
  localparam logic [7:0] CLK_CTRL_IDX  = 8'h12;
  localparam logic [7:0] MON_EN_IDX    = 8'h13;
  localparam logic [7:0] MON_LVL_IDX   = 8'h14;
  localparam logic [7:0] IRQ_STAT_IDX  = 8'h18;
  localparam logic [7:0] IRQ_MASK_IDX  = 8'h19;
  localparam logic [7:0] CLK_STAT_IDX  = 8'h1A;

  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned IDX_LSB      = 2;

  // clock control fields
  localparam int unsigned PLL_EN_BIT   = 6;
  localparam int unsigned FRAC_BIT     = 5;
  localparam int unsigned FREQ_MSB     = 4;
  localparam int unsigned FREQ_LSB     = 0;
  localparam logic [4:0]  FREQ_MAX     = 5'h17;
  localparam logic [7:0]  CLK_CTRL_RST = 8'h02;
  localparam logic [7:0]  MON_EN_RST   = 8'h00;
  localparam logic [7:0]  MON_LVL_RST  = 8'h00;

  // monitor enable fields
  localparam int unsigned METHOD_BIT   = 6;
  localparam int unsigned RAIL_MSB     = 5;
  localparam int unsigned RAILS        = 6;

  // level fields
  localparam int unsigned TOL_MSB      = 4;
  localparam int unsigned TOL_LSB      = 3;
  localparam int unsigned LVL_MSB      = 2;
  localparam int unsigned LVL_LSB      = 0;
  localparam logic [2:0]  LVL_EXT_DIV  = 3'h0;

  // interrupt status bits
  localparam int unsigned EV_APPEAR    = 0;
  localparam int unsigned EV_LOST      = 1;
  localparam int unsigned EV_CFG       = 2;
  localparam int unsigned EV_W         = 3;

  // tolerance in tenths of a percent, level in millivolts
  localparam logic [5:0] TOL_TENTHS [4] = '{6'h14, 6'h1E, 6'h28, 6'h3C};
  localparam logic [10:0] LVL_MV [8] =
    '{11'h28A, 11'h320, 11'h3E8, 11'h44C, 11'h4B0, 11'h514, 11'h708, 11'h000};

  typedef enum logic [1:0] {
    SRC_RC   = 2'b00,
    SRC_WAIT = 2'b01,
    SRC_EXT  = 2'b10
  } clk_src_t;

  typedef struct packed {
    logic [7:0] clk_ctrl;
    logic [7:0] mon_en;
    logic [7:0] mon_lvl;
  } otp_dflt_t;

  typedef struct packed {
    logic        pll_on;
    logic        use_ext;
    logic [4:0]  freq_code;
    logic [4:0]  freq_mhz;
  } clk_cfg_t;

  typedef struct packed {
    logic              ov_and_uv;
    logic [RAILS-1:0]  rail_diag_on;
    logic [5:0]        tol_tenths;
    logic [10:0]       level_mv;
    logic              high_z_input;
  } mon_cfg_t;

endpackage

// [rtl/clk_pg_cfg.sv]
// Purpose: configuration registers for clock source selection and power-good monitoring
// Assumes: APB slave, one clock, synchronous active-low reset, otp defaults stable at reset
// Notes: interrupt status bits clear on writing a one, set wins over clear
`timescale 1ns/1ns
module clk_pg_cfg
  import clk_pg_cfg_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire otp_dflt_t         otp_dflt,
  input  wire logic              dev_operating,
  input  wire logic              sync_clock_present,
  output clk_cfg_t               clk_cfg,
  output mon_cfg_t               mon_cfg,
  output logic                   freq_code_bad,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [7:0]        clk_ctrl_q;
  logic [7:0]        mon_en_q;
  logic [7:0]        mon_lvl_q;
  logic [EV_W-1:0]   stat_q;
  logic [EV_W-1:0]   mask_q;
  clk_src_t          src_q;
  logic [2:0]        settle_q;
  logic              pres_q;
  logic              freq_bad_q;
  logic [31:0]       rdata_q;

  wire logic [ADDR_W-1:0] idx      = paddr[ADDR_W-1+IDX_LSB:IDX_LSB];
  wire logic              aligned  = (paddr[IDX_LSB-1:0] == 2'b00);
  wire logic              setup    = psel && !penable;
  wire logic              access   = psel && penable;
  wire logic              wr_lane  = pstrb[0];
  wire logic              hit_clk  = aligned && (idx == CLK_CTRL_IDX);
  wire logic              hit_en   = aligned && (idx == MON_EN_IDX);
  wire logic              hit_lvl  = aligned && (idx == MON_LVL_IDX);
  wire logic              hit_stat = aligned && (idx == IRQ_STAT_IDX);
  wire logic              hit_mask = aligned && (idx == IRQ_MASK_IDX);
  wire logic              hit_cst  = aligned && (idx == CLK_STAT_IDX);
  wire logic              mapped   = hit_clk | hit_en | hit_lvl | hit_stat | hit_mask | hit_cst;
  wire logic              wr_go    = clk_en && access && pwrite && wr_lane && mapped;
  wire logic              wr_clk   = wr_go && hit_clk;
  wire logic              wr_en    = wr_go && hit_en;
  wire logic              wr_lvl   = wr_go && hit_lvl;
  wire logic              wr_stat  = wr_go && hit_stat;
  wire logic              wr_mask  = wr_go && hit_mask;

  // no wait states: setup, then access answered at once
  assign pready  = access;
  assign pslverr = access && !mapped;

  wire logic [7:0] clk_stat_rd = {5'h00, freq_bad_q, src_q};
  wire logic [7:0] rd_byte =
    hit_clk  ? clk_ctrl_q :
    hit_en   ? mon_en_q :
    hit_lvl  ? mon_lvl_q :
    hit_stat ? {{(8-EV_W){1'b0}}, stat_q} :
    hit_mask ? {{(8-EV_W){1'b0}}, mask_q} :
    hit_cst  ? clk_stat_rd : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en && setup && !pwrite) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end
  assign prdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  wire logic [7:0] wbyte = pwdata[7:0];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clk_ctrl_q <= CLK_CTRL_RST;
      mon_en_q   <= MON_EN_RST;
      mon_lvl_q  <= MON_LVL_RST;
    end else if (clk_en) begin
      if (wr_clk) clk_ctrl_q <= wbyte;
      if (wr_en)  mon_en_q   <= wbyte;
      if (wr_lvl) mon_lvl_q  <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source control

  wire logic       pll_sel   = clk_ctrl_q[PLL_EN_BIT];
  wire logic [4:0] freq_code = clk_ctrl_q[FREQ_MSB:FREQ_LSB];
  wire logic       code_bad  = (freq_code > FREQ_MAX);
  wire logic       freq_wr_on = wr_clk && pll_sel && (wbyte[FREQ_MSB:FREQ_LSB] != freq_code);

  clk_src_t src_d;
  always_comb begin
    src_d = src_q;
    case (src_q)
      SRC_RC:   if (pll_sel && sync_clock_present) src_d = SRC_WAIT;
      SRC_WAIT: if (!pll_sel || !sync_clock_present) src_d = SRC_RC;
                else if (settle_q == 3'(SETTLE_CYC - 1)) src_d = SRC_EXT;
      SRC_EXT:  if (!pll_sel || !sync_clock_present) src_d = SRC_RC;
      default:  src_d = SRC_RC;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      src_q      <= SRC_RC;
      settle_q   <= 3'h0;
      pres_q     <= 1'b0;
      freq_bad_q <= 1'b0;
    end else if (clk_en) begin
      src_q      <= src_d;
      settle_q   <= (src_q == SRC_WAIT) ? settle_q + 3'h1 : 3'h0;
      pres_q     <= sync_clock_present;
      freq_bad_q <= code_bad | (freq_wr_on | (freq_bad_q & ~wr_clk));
    end
  end

  assign clk_cfg.pll_on    = pll_sel;
  assign clk_cfg.use_ext   = (src_q == SRC_EXT);
  assign clk_cfg.freq_code = freq_code;
  assign clk_cfg.freq_mhz  = freq_code + 5'h01;
  assign freq_code_bad     = freq_bad_q;

  ////////////////////////////////////////////////////////////////////////////
  // monitor configuration

  wire logic [1:0] tol = mon_lvl_q[TOL_MSB:TOL_LSB];
  wire logic [2:0] lvl = mon_lvl_q[LVL_MSB:LVL_LSB];

  assign mon_cfg.ov_and_uv    = mon_en_q[METHOD_BIT];
  assign mon_cfg.tol_tenths   = TOL_TENTHS[tol];
  assign mon_cfg.level_mv     = LVL_MV[lvl];
  assign mon_cfg.high_z_input = (lvl == LVL_EXT_DIV);

  genvar g;
  generate
    for (g = 0; g < RAILS; g++) begin : g_rail
      assign mon_cfg.rail_diag_on[g] = mon_en_q[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  wire logic cfg_change = wr_en && dev_operating &&
                          (wbyte[METHOD_BIT:0] != mon_en_q[METHOD_BIT:0]);
  wire logic [EV_W-1:0] ev;
  assign ev[EV_APPEAR] = clk_en && pll_sel && sync_clock_present && !pres_q;
  assign ev[EV_LOST]   = clk_en && pll_sel && !sync_clock_present && pres_q;
  assign ev[EV_CFG]    = cfg_change;

  wire logic [EV_W-1:0] clr = wr_stat ? wbyte[EV_W-1:0] : '0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stat_q <= '0;
      mask_q <= '0;
    end else if (clk_en) begin
      stat_q <= (stat_q & ~clr) | ev;
      if (wr_mask) mask_q <= wbyte[EV_W-1:0];
    end
  end
  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  clk_rst_a: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> clk_ctrl_q == CLK_CTRL_RST)
    else $error("clock control not at reset value");
  pll_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pll_sel |=> !clk_cfg.use_ext || !$past(clk_en))
    else $error("external clock used with loop off");
  ext_use_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && src_q == SRC_WAIT && src_d == SRC_EXT |=> clk_cfg.use_ext)
    else $error("external clock not taken");
  appear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev[EV_APPEAR] |=> stat_q[EV_APPEAR])
    else $error("appear event lost");
  lost_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev[EV_LOST] && mask_q[EV_LOST] && !wr_mask |=> irq)
    else $error("lost event gave no interrupt");
  freq_map_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_cfg.freq_mhz == clk_cfg.freq_code + 5'h01)
    else $error("frequency map wrong");
  code_bad_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && code_bad |=> freq_code_bad)
    else $error("reserved code not flagged");
  method_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_en |=> mon_cfg.ov_and_uv == $past(wbyte[METHOD_BIT]))
    else $error("method bit not applied");
  cfg_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_change |=> stat_q[EV_CFG])
    else $error("config change interrupt missing");
  high_z_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mon_cfg.high_z_input == (mon_cfg.level_mv == LVL_MV[0]))
    else $error("input impedance mismatch");
  readback_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_lvl ##1 (clk_en && setup && !pwrite && hit_lvl) |=> prdata[7:0] == $past(wbyte, 2))
    else $error("level readback wrong");

  ext_cov: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(clk_cfg.use_ext));
  lost_cov: cover property (@(posedge clk_sys) disable iff (!rst_n) ev[EV_LOST]);
  cfg_cov: cover property (@(posedge clk_sys) disable iff (!rst_n) irq && stat_q[EV_CFG]);

endmodule // clk_pg_cfg

// [verification/clk_pg_cfg_test.sv]
// Purpose: self-checking bench for the clock and supply monitor config block
// Assumes: zero-wait APB slave, index times four is the byte address
// Notes: outputs other than the APB replies are sampled on the falling edge, after the write edge settles
`timescale 1ns/1ns
module clk_pg_cfg_test import clk_pg_cfg_pkg::*;;
  logic        clk_sys, rst_n, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  otp_dflt_t   otp_dflt;
  logic        dev_operating, sync_clock_present, freq_code_bad, irq, err;
  clk_cfg_t    clk_cfg;
  mon_cfg_t    mon_cfg;
  int          num_errors, n_checks;
  logic [5:0]  tol_exp [4] = '{6'h14, 6'h1E, 6'h28, 6'h3C};
  logic [10:0] lvl_exp [7] = '{11'h28A, 11'h320, 11'h3E8, 11'h44C, 11'h4B0, 11'h514, 11'h708};

  clk_pg_cfg #(.SETTLE_CYC(4)) clk_pg_cfg_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .otp_dflt(otp_dflt),
    .dev_operating(dev_operating), .sync_clock_present(sync_clock_present),
    .clk_cfg(clk_cfg), .mon_cfg(mon_cfg), .freq_code_bad(freq_code_bad), .irq(irq));

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'(pready), 32'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [31:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(rd, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic defaults();
    rdchk(32'h48, 32'h02);
    rdchk(32'h4C, 32'h00);
    rdchk(32'h50, 32'h00);
    settle(1);
    chk(32'(clk_cfg.freq_mhz), 32'h3);
    chk(32'(irq), 32'h0);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    num_errors++;
    summarize();
  end

  initial begin
    {rst_n, psel, penable, pwrite, dev_operating, sync_clock_present} = '0;
    clk_en = 1'b1;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    otp_dflt = '0;
    num_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    defaults();
    // reserved bits read back as written
    apb(1'b1, 32'h48, 32'h82);
    rdchk(32'h48, 32'h82);
    apb(1'b1, 32'h4C, 32'hBF);
    rdchk(32'h4C, 32'hBF);
    apb(1'b1, 32'h50, 32'hFF);
    rdchk(32'h50, 32'hFF);
    apb(1'b0, 32'h7C, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    defaults();
    // every legal frequency code, then reserved codes 24 and 31
    for (int c = 0; c < 26; c++) begin
      apb(1'b1, 32'h48, (c < 24) ? 32'(c) : ((c == 24) ? 32'h18 : 32'h1F));
      settle(2);
      if (c < 24) chk(32'(clk_cfg.freq_mhz), 32'(c + 1));
      if (c < 24) chk(32'(clk_cfg.freq_code), 32'(c));
      chk(32'(freq_code_bad), 32'(c >= 24));
    end
    apb(1'b1, 32'h48, 32'h02);
    apb(1'b1, 32'h48, 32'h42);
    apb(1'b1, 32'h48, 32'h45);
    settle(2);
    chk(32'(freq_code_bad), 32'h1);
    // loop off: sync clock ignored, no events
    apb(1'b1, 32'h48, 32'h05);
    apb(1'b1, 32'h60, 32'hFF);
    apb(1'b1, 32'h64, 32'h03);
    sync_clock_present <= 1'b1;
    settle(12);
    chk({clk_cfg.pll_on, clk_cfg.use_ext, freq_code_bad, irq}, 32'h0);
    rdchk(32'h60, 32'h00);
    sync_clock_present <= 1'b0;
    // loop on: appear and lost events
    apb(1'b1, 32'h48, 32'h45);
    sync_clock_present <= 1'b1;
    settle(12);
    chk({clk_cfg.pll_on, clk_cfg.use_ext, irq}, 32'h7);
    rdchk(32'h68, 32'h02);
    rdchk(32'h60, 32'h01);
    apb(1'b1, 32'h64, 32'h00);
    settle(1);
    chk(32'(irq), 32'h0);
    apb(1'b1, 32'h64, 32'h07);
    apb(1'b1, 32'h60, 32'h01);
    settle(1);
    chk(32'(irq), 32'h0);
    sync_clock_present <= 1'b0;
    settle(12);
    chk({clk_cfg.use_ext, irq}, 32'h1);
    rdchk(32'h60, 32'h02);
    // monitor method and per-rail enables while operating
    apb(1'b1, 32'h60, 32'hFF);
    dev_operating <= 1'b1;
    apb(1'b1, 32'h4C, 32'h40);
    settle(1);
    chk(32'(mon_cfg.ov_and_uv), 32'h1);
    rdchk(32'h60, 32'h04);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 32'h4C, 32'h1 << i);
      settle(1);
      chk({mon_cfg.ov_and_uv, mon_cfg.rail_diag_on}, 32'h1 << i);
    end
    apb(1'b1, 32'h60, 32'hFF);
    dev_operating <= 1'b0;
    apb(1'b1, 32'h4C, 32'h00);
    rdchk(32'h60, 32'h00);
    // tolerance and level codes of the first monitor
    for (int t = 0; t < 4; t++) begin
      for (int l = 0; l < 7; l++) begin
        apb(1'b1, 32'h50, 32'(t * 8 + l));
        settle(1);
        chk(32'(mon_cfg.tol_tenths), 32'(tol_exp[t]));
        chk(32'(mon_cfg.level_mv), 32'(lvl_exp[l]));
        chk(32'(mon_cfg.high_z_input), 32'(l == 0));
      end
    end
    // clock enable low: a write is lost
    clk_en <= 1'b0;
    apb(1'b1, 32'h50, 32'h01);
    clk_en <= 1'b1;
    rdchk(32'h50, 32'h1E);
    summarize();
  end
endmodule // clk_pg_cfg_test
